// File: logic/dsm_ctrl.sv
// data signal modulator control register, source gating and output pin
// assumes a single-cycle strobe bus master on sys_clk and synchronous inputs
//
// Chosen here: strobed register access and the register offsets.
`include "dsm_defs.svh"
module dsm_ctrl (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [`DSM_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic ext_mod_a,
  input wire logic ext_mod_b,
  input wire logic ext_car_a,
  input wire logic ext_car_b,
  output logic modulated_pin,
  output logic slew_limit
);
  dsm_pkg::dsm_byte_t modulator_control;
  dsm_pkg::dsm_byte_t source_select;
  logic live_output_value;
  wire logic mixed;
  wire logic pin_out;
  wire logic module_enable_bit;
  wire logic pin_output_enable;
  wire logic slew_limit_bit;
  wire logic output_invert_bit;
  wire logic software_modulation_bit;
  wire logic hit_ctrl;
  wire logic hit_sel;
  wire dsm_pkg::dsm_src_t mod_src;
  wire dsm_pkg::dsm_src_t high_carrier_src;
  wire dsm_pkg::dsm_src_t low_carrier_src;
  wire logic sel_mod;
  wire logic sel_high_carrier;
  wire logic sel_low_carrier;
  wire logic eff_mod;
  wire logic eff_high_carrier;
  wire logic eff_low_carrier;
  wire dsm_pkg::dsm_byte_t ctrl_view;
  wire dsm_pkg::dsm_byte_t next_rdata;

  assign module_enable_bit = modulator_control[`DSM_BIT_EN];
  assign pin_output_enable = modulator_control[`DSM_BIT_OE];
  assign slew_limit_bit = modulator_control[`DSM_BIT_SLR];
  assign output_invert_bit = modulator_control[`DSM_BIT_POL];
  assign software_modulation_bit = modulator_control[`DSM_BIT_SWMOD];
  assign hit_ctrl = (addr == `DSM_CTRL_ADDR);
  assign hit_sel = (addr == `DSM_SEL_ADDR);

  // source select: [1:0] modulation, [3:2] high carrier, [5:4] low carrier
  assign mod_src = dsm_pkg::dsm_src_t'(source_select[1:0]);
  assign high_carrier_src = dsm_pkg::dsm_src_t'(source_select[3:2]);
  assign low_carrier_src = dsm_pkg::dsm_src_t'(source_select[5:4]);
  // ground source on the modulation select picks the software bit
  assign sel_mod = (mod_src == dsm_pkg::DSM_SRC_EXT_A) ? ext_mod_a :
                   (mod_src == dsm_pkg::DSM_SRC_EXT_B) ? ext_mod_b : software_modulation_bit;
  assign sel_high_carrier = (high_carrier_src == dsm_pkg::DSM_SRC_EXT_A) ? ext_car_a :
                    (high_carrier_src == dsm_pkg::DSM_SRC_EXT_B) ? ext_car_b : 1'b0;
  assign sel_low_carrier = (low_carrier_src == dsm_pkg::DSM_SRC_EXT_A) ? ext_car_a :
                    (low_carrier_src == dsm_pkg::DSM_SRC_EXT_B) ? ext_car_b : 1'b0;
  // disable only overrides the path; stored selections are left alone
  assign eff_mod = module_enable_bit ? sel_mod : software_modulation_bit;
  assign eff_high_carrier = module_enable_bit & sel_high_carrier;
  assign eff_low_carrier = module_enable_bit & sel_low_carrier;

  dsm_mixer u_mixer (
    .sys_clk(sys_clk),
    .rst(rst),
    .enable(module_enable_bit),
    .modulation(eff_mod),
    .carrier_high(eff_high_carrier),
    .carrier_low(eff_low_carrier),
    .pin_oe(pin_output_enable),
    .invert(output_invert_bit),
    .mixed(mixed),
    .pin_out(pin_out)
  );

  // bits 2:1 always zero, bit 3 replaced by the sampled output
  assign ctrl_view = {modulator_control[7:4], live_output_value, 2'b00, modulator_control[0]};
  assign next_rdata = !rd ? 8'h00 :
                      hit_ctrl ? ctrl_view :
                      hit_sel ? source_select : 8'h00;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      modulator_control <= `DSM_CTRL_RESET;
      source_select <= `DSM_SEL_RESET;
    end
    else if (wr && hit_ctrl)
    begin
      modulator_control <= wdata & `DSM_CTRL_WMASK;
    end
    else if (wr && hit_sel)
    begin
      source_select <= {2'b00, wdata[5:0]};
    end
  end

  // fast modulation can alias here; this view is only a clock-rate snapshot
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      live_output_value <= 1'b0;
      rdata <= 8'h00;
      modulated_pin <= 1'b0;
      slew_limit <= 1'b1;
    end
    else
    begin
      live_output_value <= mixed;
      rdata <= next_rdata;
      modulated_pin <= pin_out;
      slew_limit <= slew_limit_bit;
    end
  end

  a_reset_disabled: assert property (@(posedge sys_clk) rst |=> (modulator_control == `DSM_CTRL_RESET))
    else $error("control not at reset value after reset");
  a_reset_pin_low: assert property (@(posedge sys_clk) rst ##1 rst |=> !modulated_pin && slew_limit)
    else $error("pin or slew output wrong during reset");
  a_unimpl_zero: assert property (@(posedge sys_clk) disable iff (rst)
    $past(rd) && $past(hit_ctrl) |-> rdata[2:1] == 2'b00)
    else $error("unimplemented bits read nonzero");
  a_live_view_read: assert property (@(posedge sys_clk) disable iff (rst)
    rd && hit_ctrl |=> rdata[`DSM_BIT_OUT] == $past(live_output_value))
    else $error("live output bit does not reflect output");
  a_live_no_write: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |-> modulator_control[3:1] == 3'b000)
    else $error("read-only bits stored a write");
  a_live_sampled: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> live_output_value == $past(mixed))
    else $error("live view not sampled from mixer");
  sequence s_disabled_hold;
    !module_enable_bit [*2];
  endsequence
  a_disabled_quiet: assert property (@(posedge sys_clk) disable iff (rst)
    s_disabled_hold |-> !mixed)
    else $error("mixer active while disabled");
  a_mix_and: assert property (@(posedge sys_clk) disable iff (rst)
    module_enable_bit |=> mixed == $past(eff_mod & (eff_mod ? eff_high_carrier : eff_low_carrier)))
    else $error("mixed value not modulation and carrier");
  sequence s_oe_off;
    !pin_output_enable ##1 1'b1;
  endsequence
  a_oe_low: assert property (@(posedge sys_clk) disable iff (rst)
    s_oe_off |=> !modulated_pin)
    else $error("pin driven while output disabled");
  a_pin_polarity: assert property (@(posedge sys_clk) disable iff (rst)
    pin_output_enable ##1 $stable(pin_output_enable) |=>
    modulated_pin == ($past(mixed) ^ $past(output_invert_bit, 2)))
    else $error("pin polarity wrong");

  // path gating checked at the mixer inputs, one level before the registers
  a_gate_disabled: assert property (@(posedge sys_clk) disable iff (rst)
    !module_enable_bit |-> !eff_high_carrier && !eff_low_carrier && (eff_mod == software_modulation_bit))
    else $error("disabled path not forced to ground and software bit");
  a_gate_enabled: assert property (@(posedge sys_clk) disable iff (rst)
    module_enable_bit |-> (eff_mod == sel_mod) && (eff_high_carrier == sel_high_carrier) && (eff_low_carrier == sel_low_carrier))
    else $error("enabled path not using selected sources");
  // selections must survive a disable, else re-enable would pick wrong sources
  a_sel_kept: assert property (@(posedge sys_clk) disable iff (rst)
    !(wr && hit_sel) |=> $stable(source_select))
    else $error("source selection changed without a write");
  a_sel_reset: assert property (@(posedge sys_clk)
    rst |=> source_select == `DSM_SEL_RESET)
    else $error("source select not cleared by reset");
  sequence s_ctrl_write;
    wr && hit_ctrl;
  endsequence
  a_ctrl_mask: assert property (@(posedge sys_clk) disable iff (rst)
    s_ctrl_write |=> modulator_control == ($past(wdata) & `DSM_CTRL_WMASK))
    else $error("control write not masked");
  a_slew_follow: assert property (@(posedge sys_clk) disable iff (rst)
    1'b1 |=> slew_limit == $past(slew_limit_bit))
    else $error("slew output does not follow its bit");
  // unmapped reads must not leak stale data onto the bus
  a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (rst)
    rd && !hit_ctrl && !hit_sel |=> rdata == 8'h00)
    else $error("unmapped read returned nonzero");
  a_rdata_idle: assert property (@(posedge sys_clk) disable iff (rst)
    !rd |=> rdata == 8'h00)
    else $error("read data present without a read");
endmodule

// File: logic/dsm_mixer.sv
// modulator mixing path: carrier choice, AND, enable gating, polarity
// assumes synchronous inputs on sys_clk; output is registered
`include "dsm_defs.svh"
module dsm_mixer (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic modulation,
  input wire logic carrier_high,
  input wire logic carrier_low,
  input wire logic pin_oe,
  input wire logic invert,
  output logic mixed,
  output logic pin_out
);
  wire logic chosen_carrier;
  wire logic next_mixed;
  wire logic next_pin_out;
  assign chosen_carrier = modulation ? carrier_high : carrier_low;
  assign next_mixed = enable & modulation & chosen_carrier;
  // inversion applies only while the pin is enabled, so a disabled pin stays low
  assign next_pin_out = pin_oe & (next_mixed ^ invert);
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mixed <= 1'b0;
      pin_out <= 1'b0;
    end
    else
    begin
      mixed <= next_mixed;
      pin_out <= next_pin_out;
    end
  end
endmodule

// File: shared/dsm_defs.svh
// offsets, bit positions and reset value of the modulator control register
// assumes inclusion by bare name from design and bench files
`ifndef DSM_DEFS_SVH
`define DSM_DEFS_SVH
`define DSM_ADDR_W 4
`define DSM_CTRL_ADDR 4'h0
`define DSM_SEL_ADDR 4'h1
`define DSM_BIT_EN 7
`define DSM_BIT_OE 6
`define DSM_BIT_SLR 5
`define DSM_BIT_POL 4
`define DSM_BIT_OUT 3
`define DSM_BIT_SWMOD 0
`define DSM_CTRL_RESET 8'h20
`define DSM_CTRL_WMASK 8'hF1
`define DSM_SEL_RESET 8'h00
`endif

// File: shared/dsm_pkg.sv
// types shared by the modulator control block
// assumes nothing of its surroundings
package dsm_pkg;
  typedef logic [7:0] dsm_byte_t;
  typedef enum logic [1:0] {DSM_SRC_GND, DSM_SRC_EXT_A, DSM_SRC_EXT_B, DSM_SRC_SPARE} dsm_src_t;
endpackage

// File: verification/tb_dsm_ctrl.sv
// bench for the modulator control block: register bus, source gating, pin path
// assumes dsm_ctrl with control at 0, source select at 1, pin two edges after inputs
`include "dsm_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, mark = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [3:0] ext = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic modulated_pin, slew_limit;
  logic [7:0] rd_q[$];
  logic pin_q[$];
  logic [1:0] rp = 2'b00;
  logic [2:0] pp = 3'b000;
  // control write, expected pin, expected readback
  logic [23:0] tbl[5] = '{24'hC0_01C8, 24'hD0_00D8, 24'h90_0098, 24'h51_0151, 24'hFE_00F8};
  int failures = 0, check_count = 0, cycles = 0, seed = 32'hf9b3, v;
  dsm_ctrl dut (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ext_mod_a(ext[0]), .ext_mod_b(ext[1]), .ext_car_a(ext[2]), .ext_car_b(ext[3]),
    .modulated_pin(modulated_pin), .slew_limit(slew_limit));
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic close_out();
    if (failures == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t read %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t pin %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    rd_q.push_back(exp);
    @(posedge sys_clk);
    rd <= 1'b0;
  endtask
  task automatic pin_note(input logic exp);
    @(posedge sys_clk);
    mark <= 1'b1;
    pin_q.push_back(exp);
    @(posedge sys_clk);
    mark <= 1'b0;
  endtask
  // read data lands one edge after the strobe, the pin two edges after its cause
  always @(negedge sys_clk)
  begin
    rp = {rp[0], rd};
    pp = {pp[1:0], mark};
    if (rp[1])
      chk_byte(rdata, rd_q.pop_front());
    if (pp[2])
      chk_bit(modulated_pin, pin_q.pop_front());
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      close_out();
    end
  end
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd_reg(4'h0, 8'h20);
    rd_reg(4'h1, 8'h00);
    pin_note(1'b0);
    @(negedge sys_clk) chk_bit(slew_limit, 1'b1);
    wr_reg(4'h5, 8'hFF);
    rd_reg(4'h5, 8'h00);
    wr_reg(4'h1, 8'h29);
    rd_reg(4'h1, 8'h29);
    ext <= 4'h9;
    foreach (tbl[i])
    begin
      wr_reg(4'h0, tbl[i][23:16]);
      repeat (2) @(posedge sys_clk);
      pin_note(tbl[i][8]);
      rd_reg(4'h0, tbl[i][7:0]);
    end
    // random sources cross with and without output inversion
    for (int k = 0; k < 2; k++)
    begin
      wr_reg(4'h0, k[0] ? 8'hD0 : 8'hC0);
      for (int i = 0; i < 64; i++)
      begin
        @(posedge sys_clk);
        v = $random(seed);
        ext <= v[3:0];
        mark <= 1'b1;
        pin_q.push_back((v[0] & v[3]) ^ k[0]);
      end
      @(posedge sys_clk) mark <= 1'b0;
    end
    repeat (3) @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk) rst <= 1'b0;
    rd_reg(4'h0, 8'h20);
    rd_reg(4'h1, 8'h00);
    pin_note(1'b0);
    repeat (4) @(posedge sys_clk);
    close_out();
  end
endmodule
